// ==== rtl/pcf_defs.svh ====
// pcf_defs.svh: bit positions, reset values and fixed codes of the control register bank
// assumes: included by bare name from pcf_fault_dec and pcf_ctrl_bank
`ifndef PCF_DEFS_SVH
`define PCF_DEFS_SVH

// ------------------------------------------------------------
// register selects for move-to / move-from control register
// ------------------------------------------------------------
`define PCF_SEL_MCW 2'h0
`define PCF_SEL_PBR 2'h3
`define PCF_SEL_EXT 2'h2

// ------------------------------------------------------------
// machine_control_word bit positions
// ------------------------------------------------------------
`define PCF_MCW_PAGING 31
`define PCF_MCW_CD 30
`define PCF_MCW_NW 29
`define PCF_MCW_AM 18
`define PCF_MCW_WP 16
`define PCF_MCW_NE 5
`define PCF_MCW_EM 2
`define PCF_MCW_MP 1
`define PCF_MCW_PROT 0
`define PCF_MCW_TS 3

// ------------------------------------------------------------
// page_base_register bit positions
// ------------------------------------------------------------
`define PCF_PBR_PCD 4
`define PCF_PBR_PWT 3

// ------------------------------------------------------------
// extension_control bit positions
// ------------------------------------------------------------
`define PCF_EXT_VME 0
`define PCF_EXT_PVI 1
`define PCF_EXT_TSD 2
`define PCF_EXT_DE 3
`define PCF_EXT_PSE 4
`define PCF_EXT_PAE 5
`define PCF_EXT_MCE 6
`define PCF_EXT_PGE 7
`define PCF_EXT_PCE 8
`define PCF_EXT_OSFX 9
`define PCF_EXT_OSXF 10

// ------------------------------------------------------------
// reset values and fixed codes
// ------------------------------------------------------------
`define PCF_EXT_RST 32'h0000_0000
`define PCF_MCW_RST 32'h0000_0000
`define PCF_PBR_RST 32'h0000_0000
`define PCF_FCW_ABSENT 16'hffff
`define PCF_FCW_PRESENT 16'h037f
`define PCF_VEC_NOFPU 8'h07
`define PCF_VEC_UD 8'h06
`define PCF_VEC_GP 8'h0d
`define PCF_VEC_AC 8'h11
`define PCF_VEC_MC 8'h12
`define PCF_PAGE_4K 2'h0
`define PCF_PAGE_4M 2'h1
`define PCF_PAGE_2M 2'h2

`endif

// ==== rtl/pcf_pkg.sv ====
// pcf_pkg.sv: types shared by the control register bank modules
// assumes: compiled before every design module
package pcf_pkg;
  // register update phase, one-hot
  typedef enum logic [2:0] {
    PCF_IDLE = 3'b001,
    PCF_WRITE = 3'b010,
    PCF_FLUSH = 3'b100
  } pcf_phase_t;
endpackage

// ==== rtl/pcf_flag_if.sv ====
// pcf_flag_if.sv: control words handed from the register bank to the decision logic, decoded fault flags handed back
// assumes: both ends share clk_sys
`timescale 1ns/1ns
interface pcf_flag_if;
  logic [31:0] mcw;
  logic [31:0] ext;
  logic fpu_trap;
  logic wait_trap;
  logic dbg_ud;
  logic tsc_fault;
  logic pmc_fault;
  logic mc_raise;
  logic ac_raise;
  logic wp_fault;
  modport bank (output mcw, output ext, input fpu_trap, input wait_trap, input dbg_ud,
    input tsc_fault, input pmc_fault, input mc_raise, input ac_raise, input wp_fault);
  modport dec (input mcw, input ext, output fpu_trap, output wait_trap, output dbg_ud,
    output tsc_fault, output pmc_fault, output mc_raise, output ac_raise, output wp_fault);
endinterface

// ==== rtl/pcf_fault_dec.sv ====
// pcf_fault_dec.sv: combinational fault decisions from the control flags
// assumes: request qualifiers arrive already synchronous to clk_sys
`timescale 1ns/1ns
`include "pcf_defs.svh"
module pcf_fault_dec (
  pcf_flag_if.dec flg,
  input wire logic fp_op,
  input wire logic wait_op,
  input wire logic dbg_alias_ref,
  input wire logic tsc_op,
  input wire logic pmc_op,
  input wire logic [1:0] cpl,
  input wire logic hw_err,
  input wire logic misaligned,
  input wire logic align_flag,
  input wire logic sup_write_ro
);
  // ------------------------------------------------------------
  // decisions
  // ------------------------------------------------------------
  always_comb begin
    flg.fpu_trap = fp_op & flg.mcw[`PCF_MCW_EM];
    // wait-type ops look at task_switched only with monitoring on, whatever emulate_fpu is
    flg.wait_trap = wait_op & flg.mcw[`PCF_MCW_MP] & flg.mcw[`PCF_MCW_TS];
    flg.dbg_ud = dbg_alias_ref & flg.ext[`PCF_EXT_DE];
    flg.tsc_fault = tsc_op & flg.ext[`PCF_EXT_TSD] & (cpl != 2'h0);
    flg.pmc_fault = pmc_op & ~flg.ext[`PCF_EXT_PCE] & (cpl != 2'h0);
    flg.mc_raise = hw_err & flg.ext[`PCF_EXT_MCE];
    flg.ac_raise = misaligned & flg.mcw[`PCF_MCW_AM] & align_flag & (cpl == 2'h3);
    flg.wp_fault = sup_write_ro & flg.mcw[`PCF_MCW_WP];
  end
endmodule

// ==== rtl/pcf_ctrl_bank.sv ====
// pcf_ctrl_bank.sv: control register bank (word, page base, extension) with fault outputs
// assumes: core drives move-to/move-from requests on clk_sys; pins are synchronised here
`timescale 1ns/1ns
`include "pcf_defs.svh"

// Overview of operation
// - emulate_fpu set traps floating-point to emulator
// - monitor_coprocessor makes wait ops test task_switched
// - control word reads ffff absent, 037f present
// - emulate set raises vector 7 on fp
// - reset clears extension_control to zero
// - extension bit 10 is os_simd_fault_support
// - extension bit 9 is os_vector_state_save
// - bit 5 widens physical address to 36 with paging on
// - global pages survive flush when enabled
// - bit 8 lets any level read counters
// - bit 4 enables 4M or 2M pages
// - virtual interrupt flag in v86 and protected
// - timestamp_restrict faults reads above level 0
// - breakpoint_extensions makes alias refs undefined-opcode
// - hw_error_trap_enable gates machine-check
// - numeric_error_report selects internal error reporting
// - supervisor_write_guard blocks supervisor read-only writes
// - align check needs mask and flag
// - no-writethrough suppresses invalidates and hit writethroughs
// - cache_disable clear enables internal cache
// - page flags drive pins on non-paged cycles with paging on
module pcf_ctrl_bank (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [1:0] reg_sel,
  input wire logic [31:0] wr_data,
  input wire logic task_switch,
  input wire logic fp_op,
  input wire logic wait_op,
  input wire logic fcw_store,
  input wire logic dbg_alias_ref,
  input wire logic tsc_op,
  input wire logic pmc_op,
  input wire logic [1:0] cpl,
  input wire logic v86_mode,
  input wire logic misaligned,
  input wire logic align_flag,
  input wire logic sup_write_ro,
  input wire logic nonpaged_cycle,
  input wire logic coproc_present_pin,
  input wire logic hw_err_pin,
  output logic [31:0] rd_data,
  output logic [15:0] fcw_data,
  output logic exc_valid,
  output logic [7:0] exc_vector,
  output logic fpu_pass,
  output logic fpu_err_internal,
  output logic cache_en,
  output logic cache_wt_en,
  output logic page_cache_off_pin,
  output logic page_writethrough_pin,
  output logic addr36_en,
  output logic [1:0] big_page_size,
  output logic virq_en,
  output logic tlb_flush,
  output logic tlb_keep_global
);
  pcf_flag_if flg ();
  pcf_pkg::pcf_phase_t phase_q, phase_d;

  logic [31:0] mcw_q, mcw_d, pbr_q, pbr_d, ext_q, ext_d;
  logic cop_s1_q, cop_s2_q, err_s1_q, err_s2_q;
  logic [31:0] rd_data_d;
  logic [15:0] fcw_data_d;
  logic exc_valid_d;
  logic [7:0] exc_vector_d;
  logic fpu_pass_d, fpu_err_d, cache_en_d, cache_wt_d, pcd_d, pwt_d, a36_d, virq_d;
  logic [1:0] page_d;
  logic flush_d, keep_d;
  logic paging;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // coprocessor presence and hardware error arrive asynchronously
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cop_s1_q <= 1'b0;
      cop_s2_q <= 1'b0;
      err_s1_q <= 1'b0;
      err_s2_q <= 1'b0;
    end else if (clk_en) begin
      cop_s1_q <= coproc_present_pin;
      cop_s2_q <= cop_s1_q;
      err_s1_q <= hw_err_pin;
      err_s2_q <= err_s1_q;
    end
  end

  // ------------------------------------------------------------
  // fault decisions
  // ------------------------------------------------------------
  assign flg.mcw = mcw_q;
  assign flg.ext = ext_q;

  pcf_fault_dec u_dec (
    .flg(flg),
    .fp_op(fp_op),
    .wait_op(wait_op),
    .dbg_alias_ref(dbg_alias_ref),
    .tsc_op(tsc_op),
    .pmc_op(pmc_op),
    .cpl(cpl),
    .hw_err(err_s2_q),
    .misaligned(misaligned),
    .align_flag(align_flag),
    .sup_write_ro(sup_write_ro)
  );

  // ------------------------------------------------------------
  // register next state
  // ------------------------------------------------------------
  // a write lands in one cycle; a page base write or a task switch raises the flush in that same cycle
  always_comb begin
    mcw_d = mcw_q;
    pbr_d = pbr_q;
    ext_d = ext_q;
    phase_d = pcf_pkg::PCF_IDLE;
    flush_d = 1'b0;
    keep_d = 1'b0;
    unique case (phase_q)
      pcf_pkg::PCF_IDLE, pcf_pkg::PCF_WRITE, pcf_pkg::PCF_FLUSH: begin
        if (wr_en) begin
          phase_d = pcf_pkg::PCF_WRITE;
          unique case (reg_sel)
            `PCF_SEL_MCW: mcw_d = wr_data;
            `PCF_SEL_PBR: begin
              pbr_d = wr_data;
              phase_d = pcf_pkg::PCF_FLUSH;
            end
            // only the documented extension bits hold state, the rest read zero
            `PCF_SEL_EXT: ext_d = {21'h0, wr_data[10:0]};
            default: ;
          endcase
        end
        if (task_switch) begin
          phase_d = pcf_pkg::PCF_FLUSH;
          mcw_d[`PCF_MCW_TS] = 1'b1;
        end
        if (phase_d == pcf_pkg::PCF_FLUSH) begin
          flush_d = 1'b1;
          keep_d = ext_q[`PCF_EXT_PGE];
        end
      end
      default: phase_d = pcf_pkg::PCF_IDLE;
    endcase
  end

  // hardware reset clears every register, extension_control included
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mcw_q <= `PCF_MCW_RST;
      pbr_q <= `PCF_PBR_RST;
      ext_q <= `PCF_EXT_RST;
      phase_q <= pcf_pkg::PCF_IDLE;
    end else if (clk_en) begin
      mcw_q <= mcw_d;
      pbr_q <= pbr_d;
      ext_q <= ext_d;
      phase_q <= phase_d;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // unmapped selects and idle cycles read zero, so the return bus stays quiet
  always_comb begin
    rd_data_d = 32'h0;
    if (rd_en) begin
      unique case (reg_sel)
        `PCF_SEL_MCW: rd_data_d = mcw_q;
        `PCF_SEL_PBR: rd_data_d = pbr_q;
        `PCF_SEL_EXT: rd_data_d = ext_q;
        default: rd_data_d = 32'h0;
      endcase
    end
    // the missing unit leaves the bus floating high, hence all ones
    fcw_data_d = fcw_data;
    if (fcw_store) begin
      fcw_data_d = cop_s2_q ? `PCF_FCW_PRESENT : `PCF_FCW_ABSENT;
    end
  end

  // read data stands one cycle; the stored control word holds until the next store
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd_data <= 32'h0;
      fcw_data <= 16'h0;
    end else if (clk_en) begin
      rd_data <= rd_data_d;
      fcw_data <= fcw_data_d;
    end
  end

  // ------------------------------------------------------------
  // exception request
  // ------------------------------------------------------------
  // priority: machine check, undefined opcode, device, general, alignment
  // one vector leaves per cycle; a losing lower cause is not held for later
  always_comb begin
    exc_valid_d = 1'b1;
    exc_vector_d = 8'h00;
    if (flg.mc_raise) begin
      exc_vector_d = `PCF_VEC_MC;
    end else if (flg.dbg_ud) begin
      exc_vector_d = `PCF_VEC_UD;
    end else if (flg.fpu_trap || flg.wait_trap) begin
      exc_vector_d = `PCF_VEC_NOFPU;
    end else if (flg.tsc_fault || flg.pmc_fault || flg.wp_fault) begin
      exc_vector_d = `PCF_VEC_GP;
    end else if (flg.ac_raise) begin
      exc_vector_d = `PCF_VEC_AC;
    end else begin
      exc_valid_d = 1'b0;
    end
  end

  // a request stands for one cycle only: the core takes it then or it is gone
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      exc_valid <= 1'b0;
      exc_vector <= 8'h00;
    end else if (clk_en) begin
      exc_valid <= exc_valid_d;
      exc_vector <= exc_vector_d;
    end
  end

  // ------------------------------------------------------------
  // mode levels and page pins
  // ------------------------------------------------------------
  assign paging = mcw_q[`PCF_MCW_PAGING] & mcw_q[`PCF_MCW_PROT];

  // mode levels trail a register write by one cycle
  always_comb begin
    fpu_pass_d = fp_op & ~mcw_q[`PCF_MCW_EM];
    fpu_err_d = mcw_q[`PCF_MCW_NE];
    cache_en_d = ~mcw_q[`PCF_MCW_CD];
    cache_wt_d = ~mcw_q[`PCF_MCW_NW];
    // page flags reach the pins only for non-paged cycles with paging on
    pcd_d = paging & nonpaged_cycle & pbr_q[`PCF_PBR_PCD];
    pwt_d = paging & nonpaged_cycle & pbr_q[`PCF_PBR_PWT];
    a36_d = paging & ext_q[`PCF_EXT_PAE];
    page_d = `PCF_PAGE_4K;
    if (ext_q[`PCF_EXT_PSE]) begin
      page_d = a36_d ? `PCF_PAGE_2M : `PCF_PAGE_4M;
    end
    // virtual interrupt support follows the mode the core runs in
    virq_d = v86_mode ? ext_q[`PCF_EXT_VME]
      : (mcw_q[`PCF_MCW_PROT] & ext_q[`PCF_EXT_PVI]);
  end

  // every level leaves from a flip-flop, one cycle after its cause
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fpu_pass <= 1'b0;
      fpu_err_internal <= 1'b0;
      cache_en <= 1'b0;
      cache_wt_en <= 1'b0;
      page_cache_off_pin <= 1'b0;
      page_writethrough_pin <= 1'b0;
      addr36_en <= 1'b0;
      big_page_size <= 2'h0;
      virq_en <= 1'b0;
    end else if (clk_en) begin
      fpu_pass <= fpu_pass_d;
      fpu_err_internal <= fpu_err_d;
      cache_en <= cache_en_d;
      cache_wt_en <= cache_wt_d;
      page_cache_off_pin <= pcd_d;
      page_writethrough_pin <= pwt_d;
      addr36_en <= a36_d;
      big_page_size <= page_d;
      virq_en <= virq_d;
    end
  end

  // ------------------------------------------------------------
  // tlb flush pulses
  // ------------------------------------------------------------
  // a pulse stands one cycle; the keep flag rides with it only under global pages
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tlb_flush <= 1'b0;
      tlb_keep_global <= 1'b0;
    end else if (clk_en) begin
      tlb_flush <= flush_d;
      tlb_keep_global <= keep_d;
    end
  end
endmodule

// ==== dv/pcf_ctrl_bank_sva.sv ====
// pcf_ctrl_bank_sva.sv: port-level assertions for the control register bank
// assumes: bound to pcf_ctrl_bank, one clock, synchronous active-low reset
`timescale 1ns/1ns
module pcf_ctrl_bank_sva (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [1:0] reg_sel,
  input wire logic [31:0] wr_data,
  input wire logic task_switch,
  input wire logic fp_op,
  input wire logic wait_op,
  input wire logic dbg_alias_ref,
  input wire logic tsc_op,
  input wire logic [1:0] cpl,
  input wire logic hw_err_pin,
  input wire logic [31:0] rd_data,
  input wire logic exc_valid,
  input wire logic [7:0] exc_vector,
  input wire logic tlb_flush,
  input wire logic tlb_keep_global
);
  logic [31:0] m_q, m_d, e_q, e_d;
  // ----------------------------------------
  // shadow registers
  // ----------------------------------------
  // shadows let decisions be tied to the flags without seeing inside the bank
  always_comb begin
    m_d = m_q;
    e_d = e_q;
    if (clk_en && wr_en && reg_sel == 2'h0) m_d = wr_data;
    if (clk_en && wr_en && reg_sel == 2'h2) e_d = {21'h0, wr_data[10:0]};
    if (clk_en && task_switch) m_d[3] = 1'b1;
  end
  always_ff @(posedge clk_sys) begin
    m_q <= nrst ? m_d : 32'h0;
    e_q <= nrst ? e_d : 32'h0;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_EXT_RESET: assert property (
    nrst && !$past(nrst) && clk_en && rd_en && reg_sel == 2'h2 |=> rd_data == 32'h0)
    else $error("extension register not zero after reset");
  AST_EXT_BITS: assert property (
    clk_en && rd_en && reg_sel == 2'h2 |=> rd_data == {21'h0, $past(e_q[10:0])})
    else $error("extension read mismatch");
  AST_FP_TRAP: assert property (
    clk_en && fp_op && m_q[2] |=> exc_valid && exc_vector == 8'h07)
    else $error("floating-point op not trapped to vector 7");
  AST_WAIT_TS: assert property (
    clk_en && wait_op && m_q[1] && m_q[3] |=> exc_valid && exc_vector == 8'h07)
    else $error("wait op ignored task switched");
  AST_DBG_UD: assert property (
    clk_en && dbg_alias_ref && e_q[3] |=> exc_valid && exc_vector == 8'h06)
    else $error("alias reference not undefined-opcode");
  AST_TSC_GP: assert property (
    clk_en && tsc_op && e_q[2] && cpl != 2'h0 |=> exc_valid && exc_vector == 8'h0d)
    else $error("timestamp read allowed above level 0");
  AST_MC_GATE: assert property (
    (clk_en && e_q[6] && hw_err_pin) [*3] |=> exc_valid && exc_vector == 8'h12)
    else $error("machine check not raised");
  AST_TLB_FLUSH: assert property (
    clk_en && wr_en && reg_sel == 2'h3 |=> tlb_flush && tlb_keep_global == $past(e_q[7]))
    else $error("page base write flush wrong");
endmodule
bind pcf_ctrl_bank pcf_ctrl_bank_sva u_sva (.clk_sys, .nrst, .clk_en, .wr_en, .rd_en,
  .reg_sel, .wr_data, .task_switch, .fp_op, .wait_op, .dbg_alias_ref, .tsc_op, .cpl,
  .hw_err_pin, .rd_data, .exc_valid, .exc_vector, .tlb_flush, .tlb_keep_global);

// ==== dv/testbench.sv ====
// testbench.sv: self-checking bench for the control register bank
// assumes: design and checker compiled first; inputs change at the falling edge
`timescale 1ns/1ns
module testbench;
  logic clk_sys = 1'b0, nrst = 1'b0, clk_en = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic task_switch = 1'b0, v86_mode = 1'b0, align_flag = 1'b0, nonpaged_cycle = 1'b0;
  logic coproc_present_pin = 1'b0, hw_err_pin = 1'b0;
  logic [1:0] reg_sel = 2'h0, cpl = 2'h0, big_page_size;
  logic [31:0] wr_data = 32'h0, rd_data;
  logic [7:0] ops = 8'h0, exc_vector;
  logic fp_op, wait_op, dbg_alias_ref, tsc_op, pmc_op, misaligned, sup_write_ro, fcw_store;
  logic [15:0] fcw_data;
  logic exc_valid, fpu_pass, fpu_err_internal, cache_en, cache_wt_en, page_cache_off_pin;
  logic page_writethrough_pin, addr36_en, virq_en, tlb_flush, tlb_keep_global;
  int n_fail = 0, total_checks = 0, cyc = 0;
  // one-hot operation strobes, so only one cause is live at a time
  assign {fcw_store, sup_write_ro, misaligned, pmc_op, tsc_op, dbg_alias_ref, wait_op,
    fp_op} = ops;
  always #20 clk_sys = ~clk_sys;
  pcf_ctrl_bank u_dut (.clk_sys, .nrst, .clk_en, .wr_en, .rd_en, .reg_sel, .wr_data,
    .task_switch, .fp_op, .wait_op, .fcw_store, .dbg_alias_ref, .tsc_op, .pmc_op, .cpl,
    .v86_mode, .misaligned, .align_flag, .sup_write_ro, .nonpaged_cycle, .coproc_present_pin,
    .hw_err_pin, .rd_data, .fcw_data, .exc_valid, .exc_vector, .fpu_pass, .fpu_err_internal,
    .cache_en, .cache_wt_en, .page_cache_off_pin, .page_writethrough_pin, .addr36_en,
    .big_page_size, .virq_en, .tlb_flush, .tlb_keep_global);
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // vector 0 means only the valid flag is compared
  task automatic chk_exc(input logic v, input logic [7:0] vec);
    total_checks++;
    if (exc_valid !== v || (v && vec != 8'h0 && exc_vector !== vec)) begin
      n_fail++;
      $display("[ERR] %0t exception %b %h exp %b %h", $time, exc_valid, exc_vector, v, vec);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [1:0] s, input logic [31:0] d);
    tick(1);
    wr_en = 1'b1;
    reg_sel = s;
    wr_data = d;
    tick(1);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [1:0] s, input logic [31:0] e);
    tick(1);
    rd_en = 1'b1;
    reg_sel = s;
    tick(1);
    rd_en = 1'b0;
    chk(rd_data, e);
  endtask
  task automatic op(input logic [7:0] o, input logic v, input logic [7:0] vec);
    tick(1);
    ops = o;
    tick(1);
    ops = 8'h0;
    chk_exc(v, vec);
  endtask
  task automatic final_report();
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard, well above the roughly 120 cycles the sequence needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    tick(6);
    nrst = 1'b1;
    rd_en = 1'b1;
    reg_sel = 2'h2;
    tick(1);
    rd_en = 1'b0;
    chk(rd_data, 32'h0);
    wr(2'h2, 32'hffff_ffff);
    rd(2'h2, 32'h0000_07ff);
    wr(2'h1, 32'hffff_ffff);
    rd(2'h1, 32'h0);
    clk_en = 1'b0;
    wr(2'h2, 32'h0);
    clk_en = 1'b1;
    rd(2'h2, 32'h0000_07ff);
    wr(2'h2, 32'h0);
    wr(2'h0, 32'h0000_0024);
    rd(2'h0, 32'h0000_0024);
    chk({fpu_pass, fpu_err_internal}, 2'b01);
    op(8'h01, 1'b1, 8'h07);
    wr(2'h0, 32'h0000_0002);
    op(8'h01, 1'b0, 8'h0);
    chk(fpu_pass, 1'b1);
    op(8'h02, 1'b0, 8'h0);
    task_switch = 1'b1;
    tick(1);
    task_switch = 1'b0;
    chk({tlb_flush, tlb_keep_global}, 2'b10);
    rd(2'h0, 32'h0000_000a);
    op(8'h02, 1'b1, 8'h07);
    wr(2'h0, 32'h0000_0008);
    op(8'h02, 1'b0, 8'h0);
    wr(2'h2, 32'h0000_000c);
    cpl = 2'h3;
    op(8'h04, 1'b1, 8'h06);
    op(8'h08, 1'b1, 8'h0d);
    op(8'h10, 1'b1, 8'h0d);
    wr(2'h2, 32'h0000_0100);
    op(8'h04, 1'b0, 8'h0);
    op(8'h08, 1'b0, 8'h0);
    op(8'h10, 1'b0, 8'h0);
    wr(2'h0, 32'h0004_0000);
    align_flag = 1'b1;
    op(8'h20, 1'b1, 8'h11);
    align_flag = 1'b0;
    op(8'h20, 1'b0, 8'h0);
    cpl = 2'h0;
    wr(2'h0, 32'h8001_0001);
    op(8'h40, 1'b1, 8'h0d);
    wr(2'h0, 32'h8000_0001);
    op(8'h40, 1'b0, 8'h0);
    wr(2'h2, 32'h0000_0040);
    hw_err_pin = 1'b1;
    tick(3);
    chk_exc(1'b1, 8'h12);
    wr(2'h2, 32'h0);
    tick(3);
    chk_exc(1'b0, 8'h0);
    hw_err_pin = 1'b0;
    wr(2'h0, 32'h6000_0000);
    tick(2);
    chk({cache_en, cache_wt_en}, 2'b00);
    wr(2'h0, 32'h8000_0001);
    tick(2);
    chk({cache_en, cache_wt_en}, 2'b11);
    wr(2'h2, 32'h0000_0030);
    tick(2);
    chk({addr36_en, big_page_size}, 3'b110);
    wr(2'h2, 32'h0000_0091);
    v86_mode = 1'b1;
    tick(2);
    chk({addr36_en, big_page_size, virq_en}, 4'b0011);
    wr(2'h3, 32'h0000_0018);
    chk({tlb_flush, tlb_keep_global}, 2'b11);
    nonpaged_cycle = 1'b1;
    tick(2);
    chk({page_cache_off_pin, page_writethrough_pin}, 2'b11);
    wr(2'h3, 32'h0000_0010);
    tick(2);
    chk({page_cache_off_pin, page_writethrough_pin, tlb_flush}, 3'b100);
    op(8'h80, 1'b0, 8'h0);
    chk(fcw_data, 32'h0000_ffff);
    coproc_present_pin = 1'b1;
    tick(3);
    op(8'h80, 1'b0, 8'h0);
    chk(fcw_data, 32'h0000_037f);
    v86_mode = 1'b0;
    wr(2'h2, 32'h0000_0002);
    tick(2);
    chk(virq_en, 1'b1);
    wr(2'h2, 32'h0000_0001);
    tick(2);
    chk(virq_en, 1'b0);
    final_report();
  end
endmodule
